// [design/led_scan_consts.svh]
/*
 * Constants of the lamp matrix scanner: register offsets, field positions,
 * reset values and the on-time step.
 * Assumes a 20 MHz ref_clk.
 */
`ifndef LED_SCAN_CONSTS_SVH
`define LED_SCAN_CONSTS_SVH

`define OFF_START 8'hAF
`define OFF_CONTROL 8'hB0
`define OFF_WIDTH1 8'hB1
`define OFF_WIDTH2 8'hB2
`define OFF_DRIVE 8'hB3

`define MEM_PAGE 12'h020
`define MEM_SEL_BIT 3

`define START_BIT 0
`define SIZE_HI 4
`define SIZE_LO 2
`define MODE_BIT 1
`define LOCK_BIT 0
`define DRIVE_HI 3

`define RESET_REG 8'h00
`define LAMP_PINS 9

`define STEP_TIME_NS 16000
`define CLK_PERIOD_NS 50
`define STEP_CYCLES ((`STEP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [design/led_scan_pkg.sv]
/*
 * Types shared by the lamp matrix scanner modules.
 * Assumes nothing beyond a single clock domain.
 */
package led_scan_pkg;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} sfr_req_s;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} mem_req_s;

	typedef struct packed {
		logic [8:0] level;
		logic [8:0] oe_n;
	} pin_drive_s;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_LOAD,
		ST_LIGHT
	} scan_state_e;

endpackage

// [design/on_time_prescaler.sv]
/*
 * Divides ref_clk down to the 16 us on-time tick.
 * Assumes clear is driven from the same clock domain.
 */
`include "led_scan_consts.svh"
module on_time_prescaler #(
	parameter int unsigned CYCLES = `STEP_CYCLES
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic ce,
	input wire logic clear,
	output logic tick
);
	import led_scan_pkg::*;

	localparam int W = $clog2(CYCLES + 1);
	localparam logic [W-1:0] LAST = W'(CYCLES - 1);
	localparam logic [W:0] PERIOD = (W + 1)'(CYCLES);

	logic [W-1:0] count_ff;
	logic [W-1:0] nxt_count_ff;
	logic tick_ff;
	logic nxt_tick_ff;
	logic [W:0] gap_ff;

	always_comb begin
		nxt_count_ff = count_ff + 1'b1;
		nxt_tick_ff = 1'b0;
		if (clear) begin
			nxt_count_ff = '0;
		end else if (count_ff == LAST) begin
			nxt_count_ff = '0;
			nxt_tick_ff = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			count_ff <= '0;
			tick_ff <= 1'b0;
		end else if (ce) begin
			count_ff <= nxt_count_ff;
			tick_ff <= nxt_tick_ff;
		end
	end

	assign tick = tick_ff;

	// cycles since the last clear or tick
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			gap_ff <= '0;
		end else if (ce) begin
			if (clear) begin
				gap_ff <= '0;
			end else if (tick_ff) begin
				gap_ff <= (W + 1)'(1);
			end else if (gap_ff != '1) begin
				gap_ff <= gap_ff + 1'b1;
			end
		end
	end

	tick_period_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		tick_ff && gap_ff != '0 |-> gap_ff == PERIOD)
		else $error("on-time tick period wrong");

endmodule

// [design/lighting_memory.sv]
/*
 * Lighting memory: eight bytes of lamp on bits, eight of on-time choices.
 * Assumes the data bus request is one cycle long and same-clock.
 */
`include "led_scan_consts.svh"
module lighting_memory (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic ce,
	input led_scan_pkg::mem_req_s mem_req,
	input wire logic [4:0] pair_index,
	output logic [1:0] lamp_on_bit,
	output logic [1:0] lamp_time_choice,
	output logic [7:0] mem_rdata
);
	import led_scan_pkg::*;

	logic [7:0] store_ff [0:15];
	logic [7:0] nxt_store [0:15];
	logic [7:0] rdata_ff;
	logic [7:0] nxt_rdata_ff;
	logic hit;

	assign hit = mem_req.addr[15:4] == `MEM_PAGE;

	always_comb begin
		nxt_store = store_ff;
		nxt_rdata_ff = rdata_ff;
		if (hit && mem_req.wr) begin
			nxt_store[mem_req.addr[3:0]] = mem_req.wdata;
		end
		if (mem_req.rd) begin
			nxt_rdata_ff = hit ? store_ff[mem_req.addr[3:0]] : 8'h00;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			for (int i = 0; i < 16; i++) begin
				store_ff[i] <= 8'h00;
			end
			rdata_ff <= 8'h00;
		end else if (ce) begin
			store_ff <= nxt_store;
			rdata_ff <= nxt_rdata_ff;
		end
	end

	// lamp n: byte n/8, bit n mod 8; choices sit eight bytes higher
	assign lamp_on_bit = store_ff[{1'b0, pair_index[4:2]}][{pair_index[1:0], 1'b0} +: 2];
	assign lamp_time_choice = store_ff[{1'b1, pair_index[4:2]}][{pair_index[1:0], 1'b0} +: 2];
	assign mem_rdata = rdata_ff;

endmodule

// [design/led_dot_matrix_scanner.sv]
/*
 * Charlieplexed lamp matrix scanner with its special-function registers.
 * Assumes the register and data buses are same-clock, one-cycle strobes,
 * and that pin multiplexing is set up by software elsewhere.
 */
`include "led_scan_consts.svh"
// Functional notes
// - up to 64 lamps, seven lattice sizes
// - two lamps share one cathode per step
// - first on-time is (width1+1) x 16 us
// - second on-time is (width2+1) x 16 us
// - each lamp picks first or second on-time
// - lattice size enables its subset of pins
// - controller, two counters, comparator, memory
// - memory bit one lights lamp, zero darkens
// - hardware compares addresses, drives pins itself
// - lamp address fixed for every lattice size
// - size field in control bits 4 to 2
// - control bit 1 picks cycle or single pass
// - control bit 0 locks common pins as IO
// - locked pins follow IO drive while size is zero and start bit clear
// - four-bit sink current level, zero to fifteen
// - start bit 0 starts scanning, resets zero
// - on bits at 200H, lamp n bit n mod 8
// - on-time choice bits at 208H, one selects second
module led_dot_matrix_scanner (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic ce,
	input led_scan_pkg::sfr_req_s sfr_req,
	output logic [7:0] sfr_rdata,
	input led_scan_pkg::mem_req_s mem_req,
	output logic [7:0] mem_rdata,
	input led_scan_pkg::pin_drive_s gpio_drive,
	output led_scan_pkg::pin_drive_s lamp_pins,
	output logic [8:0] lamp_fn_en,
	output logic [3:0] sink_current_setting,
	output logic common_pin_lock,
	output logic scan_done,
	output logic scan_busy
);
	import led_scan_pkg::*;
	function automatic logic [3:0] rows_of(input logic [2:0] s);
		case (s)
			3'h1: rows_of = 4'h4;
			3'h2: rows_of = 4'h5;
			3'h3, 3'h4: rows_of = 4'h6;
			3'h5: rows_of = 4'h7;
			3'h6, 3'h7: rows_of = 4'h8;
			default: rows_of = 4'h0;
		endcase
	endfunction
	function automatic logic [3:0] cols_of(input logic [2:0] s);
		case (s)
			3'h1: cols_of = 4'h4;
			3'h2: cols_of = 4'h5;
			3'h3: cols_of = 4'h6;
			3'h4, 3'h5, 3'h6: cols_of = 4'h7;
			3'h7: cols_of = 4'h8;
			default: cols_of = 4'h0;
		endcase
	endfunction
	function automatic logic [8:0] pin_mask_of(input logic [2:0] s);
		case (s)
			3'h1: pin_mask_of = 9'h01F;
			3'h2: pin_mask_of = 9'h03F;
			3'h3: pin_mask_of = 9'h07F;
			3'h4, 3'h5, 3'h6: pin_mask_of = 9'h0FF;
			3'h7: pin_mask_of = 9'h1FF;
			default: pin_mask_of = 9'h000;
		endcase
	endfunction
	// anode skips the cathode pin of its row
	function automatic logic [3:0] anode_of(input logic [2:0] row, input logic [2:0] col);
		anode_of = (col < row) ? {1'b0, col} : {1'b0, col} + 4'h1;
	endfunction

	// register group
	logic start_ff, nxt_start_ff;
	logic [7:0] control_ff, nxt_control_ff;
	logic [7:0] width1_ff, nxt_width1_ff;
	logic [7:0] width2_ff, nxt_width2_ff;
	logic [3:0] drive_ff, nxt_drive_ff;
	logic [7:0] sfr_rdata_ff, nxt_sfr_rdata_ff;

	// scan group
	scan_state_e state_ff, nxt_state_ff;
	logic [2:0] row_ff, nxt_row_ff;
	logic [1:0] pair_ff, nxt_pair_ff;
	logic [7:0] cnt_ff, nxt_cnt_ff;
	logic [7:0] w0_ff, nxt_w0_ff;
	logic [7:0] w1_ff, nxt_w1_ff;
	logic [3:0] a0_ff, nxt_a0_ff;
	logic [3:0] a1_ff, nxt_a1_ff;
	logic lit0_ff, nxt_lit0_ff;
	logic lit1_ff, nxt_lit1_ff;
	pin_drive_s pins_ff, nxt_pins_ff;
	logic [8:0] fn_en_ff, nxt_fn_en_ff;
	logic done_ff, nxt_done_ff;
	logic busy_ff, nxt_busy_ff;

	logic [2:0] size;
	logic cycle_mode, lock, tick, last_pair, last_row, start_wr;
	logic [3:0] rows, cols;
	logic [1:0] lamp_on, lamp_choice;
	logic [7:0] wmax;

	assign size = control_ff[`SIZE_HI:`SIZE_LO];
	assign cycle_mode = control_ff[`MODE_BIT];
	assign lock = control_ff[`LOCK_BIT];
	assign rows = rows_of(size);
	assign cols = cols_of(size);
	assign start_wr = sfr_req.wr && sfr_req.addr == `OFF_START;

	// on-time tick and lighting memory
	on_time_prescaler u_prescaler (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.ce(ce),
		.clear(state_ff == ST_LOAD),
		.tick(tick)
	);

	lighting_memory u_memory (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.ce(ce),
		.mem_req(mem_req),
		.pair_index({row_ff, pair_ff}),
		.lamp_on_bit(lamp_on),
		.lamp_time_choice(lamp_choice),
		.mem_rdata(mem_rdata)
	);

	// register next values
	always_comb begin
		nxt_start_ff = start_ff;
		nxt_control_ff = control_ff;
		nxt_width1_ff = width1_ff;
		nxt_width2_ff = width2_ff;
		nxt_drive_ff = drive_ff;
		nxt_sfr_rdata_ff = sfr_rdata_ff;
		if (nxt_done_ff) begin
			nxt_start_ff = 1'b0;
		end
		if (sfr_req.wr) begin
			case (sfr_req.addr)
				`OFF_START: nxt_start_ff = sfr_req.wdata[`START_BIT];
				`OFF_CONTROL: nxt_control_ff = {3'h0, sfr_req.wdata[4:0]};
				`OFF_WIDTH1: nxt_width1_ff = sfr_req.wdata;
				`OFF_WIDTH2: nxt_width2_ff = sfr_req.wdata;
				`OFF_DRIVE: nxt_drive_ff = sfr_req.wdata[`DRIVE_HI:0];
				default: nxt_start_ff = nxt_start_ff;
			endcase
		end
		if (sfr_req.rd) begin
			case (sfr_req.addr)
				`OFF_START: nxt_sfr_rdata_ff = {7'h00, start_ff};
				`OFF_CONTROL: nxt_sfr_rdata_ff = control_ff;
				`OFF_WIDTH1: nxt_sfr_rdata_ff = width1_ff;
				`OFF_WIDTH2: nxt_sfr_rdata_ff = width2_ff;
				`OFF_DRIVE: nxt_sfr_rdata_ff = {4'h0, drive_ff};
				default: nxt_sfr_rdata_ff = 8'h00;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			start_ff <= 1'b0;
			control_ff <= `RESET_REG;
			width1_ff <= `RESET_REG;
			width2_ff <= `RESET_REG;
			drive_ff <= 4'h0;
			sfr_rdata_ff <= 8'h00;
		end else if (ce) begin
			start_ff <= nxt_start_ff;
			control_ff <= nxt_control_ff;
			width1_ff <= nxt_width1_ff;
			width2_ff <= nxt_width2_ff;
			drive_ff <= nxt_drive_ff;
			sfr_rdata_ff <= nxt_sfr_rdata_ff;
		end
	end

	// scan controller next values
	always_comb begin
		nxt_state_ff = state_ff;
		nxt_row_ff = row_ff;
		nxt_pair_ff = pair_ff;
		nxt_cnt_ff = cnt_ff;
		nxt_w0_ff = w0_ff;
		nxt_w1_ff = w1_ff;
		nxt_a0_ff = a0_ff;
		nxt_a1_ff = a1_ff;
		nxt_lit0_ff = lit0_ff;
		nxt_lit1_ff = lit1_ff;
		nxt_done_ff = 1'b0;
		wmax = (w0_ff > w1_ff) ? w0_ff : w1_ff;
		last_pair = ({1'b0, pair_ff, 1'b0} + 4'h2) >= cols;
		last_row = ({1'b0, row_ff} + 4'h1) >= rows;
		case (state_ff)
			ST_IDLE: begin
				nxt_lit0_ff = 1'b0;
				nxt_lit1_ff = 1'b0;
				if (start_ff && size != 3'h0) begin
					nxt_state_ff = ST_LOAD;
					nxt_row_ff = 3'h0;
					nxt_pair_ff = 2'h0;
				end
			end
			ST_LOAD: begin
				nxt_cnt_ff = 8'h00;
				nxt_a0_ff = anode_of(row_ff, {pair_ff, 1'b0});
				nxt_a1_ff = anode_of(row_ff, {pair_ff, 1'b1});
				nxt_w0_ff = lamp_choice[0] ? width2_ff : width1_ff;
				nxt_w1_ff = lamp_choice[1] ? width2_ff : width1_ff;
				nxt_lit0_ff = lamp_on[0] && ({1'b0, pair_ff, 1'b0} < cols);
				nxt_lit1_ff = lamp_on[1] && ({1'b0, pair_ff, 1'b1} < cols);
				nxt_state_ff = ST_LIGHT;
			end
			ST_LIGHT: begin
				if (!start_ff || size == 3'h0) begin
					nxt_state_ff = ST_IDLE;
				end else if (tick) begin
					nxt_cnt_ff = cnt_ff + 8'h01;
					if (cnt_ff == w0_ff) begin
						nxt_lit0_ff = 1'b0;
					end
					if (cnt_ff == w1_ff) begin
						nxt_lit1_ff = 1'b0;
					end
					if (cnt_ff == wmax) begin
						nxt_state_ff = ST_LOAD;
						nxt_pair_ff = last_pair ? 2'h0 : pair_ff + 2'h1;
						if (last_pair) begin
							nxt_row_ff = last_row ? 3'h0 : row_ff + 3'h1;
						end
						if (last_pair && last_row && !cycle_mode) begin
							nxt_state_ff = ST_IDLE;
							nxt_done_ff = 1'b1;
						end
					end
				end
			end
			default: nxt_state_ff = ST_IDLE;
		endcase
		nxt_pins_ff = '{level: 9'h000, oe_n: 9'h1FF};
		if (nxt_state_ff == ST_LIGHT) begin
			nxt_pins_ff.oe_n[nxt_row_ff] = 1'b0;
			if (nxt_lit0_ff) begin
				nxt_pins_ff.level[nxt_a0_ff] = 1'b1;
				nxt_pins_ff.oe_n[nxt_a0_ff] = 1'b0;
			end
			if (nxt_lit1_ff) begin
				nxt_pins_ff.level[nxt_a1_ff] = 1'b1;
				nxt_pins_ff.oe_n[nxt_a1_ff] = 1'b0;
			end
		end else if (lock && size == 3'h0 && !start_ff) begin
			nxt_pins_ff = gpio_drive;
		end
		nxt_fn_en_ff = pin_mask_of(size);
		nxt_busy_ff = nxt_state_ff != ST_IDLE;
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			state_ff <= ST_IDLE;
			row_ff <= 3'h0;
			pair_ff <= 2'h0;
			cnt_ff <= 8'h00;
			w0_ff <= 8'h00;
			w1_ff <= 8'h00;
			a0_ff <= 4'h0;
			a1_ff <= 4'h0;
			lit0_ff <= 1'b0;
			lit1_ff <= 1'b0;
			pins_ff <= {9'h000, 9'h1FF};
			fn_en_ff <= 9'h000;
			done_ff <= 1'b0;
			busy_ff <= 1'b0;
		end else if (ce) begin
			state_ff <= nxt_state_ff;
			row_ff <= nxt_row_ff;
			pair_ff <= nxt_pair_ff;
			cnt_ff <= nxt_cnt_ff;
			w0_ff <= nxt_w0_ff;
			w1_ff <= nxt_w1_ff;
			a0_ff <= nxt_a0_ff;
			a1_ff <= nxt_a1_ff;
			lit0_ff <= nxt_lit0_ff;
			lit1_ff <= nxt_lit1_ff;
			pins_ff <= nxt_pins_ff;
			fn_en_ff <= nxt_fn_en_ff;
			done_ff <= nxt_done_ff;
			busy_ff <= nxt_busy_ff;
		end
	end

	assign sfr_rdata = sfr_rdata_ff;
	assign lamp_pins = pins_ff;
	assign lamp_fn_en = fn_en_ff;
	assign sink_current_setting = drive_ff;
	assign common_pin_lock = control_ff[`LOCK_BIT];
	assign scan_done = done_ff;
	assign scan_busy = busy_ff;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	pin_subset_a: assert property (ce |=> lamp_fn_en == pin_mask_of($past(size)))
		else $error("lamp pin enables do not match size");
	cathode_low_a: assert property (state_ff == ST_LIGHT |-> !lamp_pins.oe_n[row_ff] && !lamp_pins.level[row_ff])
		else $error("cathode not driven low");
	two_lamps_a: assert property (state_ff == ST_LIGHT |-> $countones(lamp_pins.level & ~lamp_pins.oe_n) <= 2)
		else $error("more than two anodes driven");
	first_time_a: assert property (state_ff == ST_LIGHT && cnt_ff > w0_ff |-> lamp_pins.oe_n[a0_ff])
		else $error("lamp lit past its on-time");
	second_time_a: assert property (state_ff == ST_LIGHT && cnt_ff > w1_ff |-> lamp_pins.oe_n[a1_ff])
		else $error("second lamp lit past its on-time");
	time_choice_a: assert property (ce && state_ff == ST_LOAD |=>
		w0_ff == ($past(lamp_choice[0]) ? $past(width2_ff) : $past(width1_ff)))
		else $error("wrong on-time chosen");
	dark_lamp_a: assert property (ce && state_ff == ST_LOAD && !lamp_on[0] |=> !lit0_ff)
		else $error("dark lamp lit");
	start_bit_a: assert property (ce && start_wr && sfr_req.wdata[0] |=> start_ff)
		else $error("start write lost");
	pass_done_a: assert property (scan_done && !$past(start_wr) |-> !start_ff && !scan_busy)
		else $error("single pass did not stop");
	io_follow_a: assert property (ce && lock && size == 3'h0 && !start_ff && state_ff == ST_IDLE
		|=> lamp_pins == $past(gpio_drive))
		else $error("locked pins ignore IO drive");
	cycle_wrap_c: cover property (state_ff == ST_LIGHT && cycle_mode ##1 state_ff == ST_LOAD && row_ff == 3'h0);
	pass_end_c: cover property (scan_done);
	two_lit_c: cover property (state_ff == ST_LIGHT && lit0_ff && lit1_ff && w0_ff != w1_ff);

endmodule

// [verification/lamp_matrix_model.sv]
/*
 * Lamp matrix model: 8x8 common-cathode lamps on nine pins, lit vector out.
 * Assumes lamp_pins come from the scanner, oe_n low = driven.
 */
module lamp_matrix_model (
	input led_scan_pkg::pin_drive_s lamp_pins,
	input logic [8:0] fn_en,
	output logic [63:0] lit
);
	timeunit 1ns;
	timeprecision 100ps;
	import led_scan_pkg::*;

	// lamp row*8+col: cathode on pin row, anode on pin col, or col+1 past the row
	always_comb begin
		lit = '0;
		for (int r = 0; r < 8; r++) begin
			for (int c = 0; c < 8; c++) begin
				// a pin reaches the lamps only with its lamp function switched in
				lit[r * 8 + c] = !lamp_pins.oe_n[r] && !lamp_pins.level[r]
					&& !lamp_pins.oe_n[c < r ? c : c + 1] && lamp_pins.level[c < r ? c : c + 1]
					&& fn_en[r] && fn_en[c < r ? c : c + 1];
			end
		end
	end
endmodule

// [verification/tb_led_dot_matrix_scanner.sv]
/*
 * Testbench of the lamp matrix scanner: registers, memory, pins and scans.
 * Assumes the lamp model beside the design and a 20 MHz ref_clk.
 */
`include "led_scan_consts.svh"
module tb_led_dot_matrix_scanner;
	timeunit 1ns;
	timeprecision 100ps;
	import led_scan_pkg::*;

	logic ref_clk = 0;
	logic reset_n = 0;
	logic ce = 1;
	sfr_req_s sfr_req = '0;
	mem_req_s mem_req = '0;
	pin_drive_s gpio_drive = '0;
	logic [7:0] sfr_rdata;
	logic [7:0] mem_rdata;
	pin_drive_s lamp_pins;
	logic [8:0] lamp_fn_en;
	logic [3:0] sink_current_setting;
	logic common_pin_lock;
	logic scan_done;
	logic scan_busy;
	logic [63:0] lit;
	logic [7:0] sfr_exp[$];
	logic [7:0] mem_exp[$];
	logic sfr_rd_q = 0;
	logic mem_rd_q = 0;
	logic [7:0] d;
	logic [8:0] en_tab[8] = '{9'h000, 9'h01F, 9'h03F, 9'h07F, 9'h0FF, 9'h0FF, 9'h0FF, 9'h1FF};
	int num_errors = 0;
	int cmp_count = 0;
	int done_count = 0;
	int overlap = 0;
	int lit_cnt[64];

	always #25 ref_clk = ~ref_clk;

	led_dot_matrix_scanner i_dut (
		.ref_clk(ref_clk), .reset_n(reset_n), .ce(ce),
		.sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .mem_req(mem_req), .mem_rdata(mem_rdata),
		.gpio_drive(gpio_drive), .lamp_pins(lamp_pins), .lamp_fn_en(lamp_fn_en),
		.sink_current_setting(sink_current_setting), .common_pin_lock(common_pin_lock),
		.scan_done(scan_done), .scan_busy(scan_busy)
	);

	lamp_matrix_model i_lamps (.lamp_pins(lamp_pins), .fn_en(lamp_fn_en), .lit(lit));

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic end_sim;
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// one strobe cycle on the register bus or the memory bus
	task automatic bus(input bit mem, input bit wr, input logic [15:0] addr, input logic [7:0] data);
		@(posedge ref_clk);
		#2;
		if (mem)
			mem_req = '{addr, data, wr, !wr};
		else
			sfr_req = '{addr[7:0], data, wr, !wr};
		@(posedge ref_clk);
		#2;
		mem_req = '0;
		sfr_req = '0;
	endtask

	task automatic rd(input bit mem, input logic [15:0] addr, input logic [7:0] exp);
		if (mem)
			mem_exp.push_back(exp);
		else
			sfr_exp.push_back(exp);
		bus(mem, 0, addr, 8'h00);
	endtask

	task automatic wait_done;
		for (int i = 0; i < 20000 && done_count == 0; i++)
			@(posedge ref_clk);
		if (done_count == 0) begin
			num_errors++;
			end_sim;
		end
	endtask

	// read data is compared one cycle after the taken strobe
	always @(posedge ref_clk) begin
		if (sfr_rd_q)
			check(sfr_rdata, sfr_exp.pop_front());
		if (mem_rd_q)
			check(mem_rdata, mem_exp.pop_front());
		sfr_rd_q <= sfr_req.rd && ce;
		mem_rd_q <= mem_req.rd && ce;
		if (scan_done === 1'b1)
			done_count++;
		if ($countones(lit) > 2)
			overlap++;
		for (int i = 0; i < 64; i++)
			if (lit[i] === 1'b1)
				lit_cnt[i]++;
	end

	initial begin
		void'($urandom(32'hEC0D));
		repeat (8) @(posedge ref_clk);
		#2;
		reset_n = 1;
		// frozen and unmapped writes are dropped
		ce = 0;
		bus(0, 1, `OFF_WIDTH1, 8'h55);
		ce = 1;
		bus(0, 1, 16'h00B4, 8'hFF);
		for (int a = 'hAF; a <= 'hB4; a++)
			rd(0, a[15:0], 8'h00);
		for (int a = 'hAF; a <= 'hB3; a++) begin
			d = 8'($urandom);
			bus(0, 1, a[15:0], d);
			rd(0, a[15:0], d & (a == 'hAF ? 8'h01 : a == 'hB0 ? 8'h1F : a == 'hB3 ? 8'h0F : 8'hFF));
		end
		check(sink_current_setting, d[3:0]);
		// locked common pins follow the general IO drive
		bus(0, 1, `OFF_START, 8'h00);
		bus(0, 1, `OFF_CONTROL, 8'h01);
		gpio_drive = {9'($urandom), 9'($urandom)};
		repeat (2) @(posedge ref_clk);
		check(common_pin_lock, 1);
		check(lamp_pins, gpio_drive);
		for (int s = 0; s < 8; s++) begin
			bus(0, 1, `OFF_CONTROL, {3'b000, s[2:0], 2'b00});
			repeat (2) @(posedge ref_clk);
			check(lamp_fn_en, en_tab[s]);
		end
		bus(1, 1, 16'h0210, 8'hFF);
		rd(1, 16'h0210, 8'h00);
		for (int k = 0; k < 16; k++) begin
			d = 8'($urandom);
			bus(1, 1, 16'h0200 + k[15:0], d);
			rd(1, 16'h0200 + k[15:0], d);
		end
		// lamps 0, 1, 8 first time, 9 second time, 4 outside the 4x4 lattice
		for (int k = 0; k < 16; k++)
			bus(1, 1, 16'h0200 + k[15:0], k == 0 ? 8'h13 : k == 1 ? 8'h03 : k == 9 ? 8'h02 : 8'h00);
		bus(0, 1, `OFF_WIDTH1, 8'h00);
		bus(0, 1, `OFF_WIDTH2, 8'h02);
		bus(0, 1, `OFF_CONTROL, 8'h04);
		lit_cnt = '{default: 0};
		done_count = 0;
		overlap = 0;
		bus(0, 1, `OFF_START, 8'h01);
		wait_done();
		check((lit_cnt[0] + 160) / 320, 1);
		check((lit_cnt[1] + 160) / 320, 1);
		check((lit_cnt[9] + 160) / 320, 3);
		check((lit_cnt[8] + 160) / 320, 1);
		check(lit_cnt[2] + lit_cnt[4], 0);
		check(overlap, 0);
		rd(0, `OFF_START, 8'h00);
		check(scan_busy, 0);
		// cycle mode keeps scanning with no done pulse
		lit_cnt = '{default: 0};
		bus(0, 1, `OFF_CONTROL, 8'h06);
		bus(0, 1, `OFF_START, 8'h01);
		repeat (8000) @(posedge ref_clk);
		check(scan_busy, 1);
		check(done_count, 1);
		check(lit_cnt[0] >= 640, 1);
		bus(0, 1, `OFF_START, 8'h00);
		repeat (2) @(posedge ref_clk);
		check(scan_busy, 0);
		check(lamp_pins.oe_n, 9'h1FF);
		// 8x8 single pass: same addresses, lamps 4 and 63 now inside
		lit_cnt = '{default: 0};
		done_count = 0;
		overlap = 0;
		bus(1, 1, 16'h0207, 8'h80);
		bus(0, 1, `OFF_CONTROL, 8'h1C);
		bus(0, 1, `OFF_START, 8'h01);
		wait_done();
		check((lit_cnt[63] + 160) / 320, 1);
		check((lit_cnt[9] + 160) / 320, 3);
		check((lit_cnt[4] + 160) / 320, 1);
		check(overlap, 0);
		end_sim;
	end
endmodule
